// >>> include/sram_link_defs.svh
`ifndef SRAM_LINK_DEFS_SVH
`define SRAM_LINK_DEFS_SVH
// beat and lane geometry
`define LANE_BITS        9
// waits, in their own units
`define POWER_UP_WAIT_NS 20000
`define CLOCK_PERIOD_NS  100
`define POWER_UP_CYCLES  ((`POWER_UP_WAIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define DLL_LOCK_CYCLES  2048
`define CLOCK_STOP_NS    30
// impedance calibration
`define IMP_PERIOD       1024
`define IMP_CODE_BITS    6
`define IMP_CODE_RESET   6'h20
`endif

// >>> include/sram_link_pkg.sv
package sram_link_pkg;
  // command decoded on a true-clock rise
  typedef enum logic [1:0] {
    CMD_DESELECT,
    CMD_READ,
    CMD_WRITE
  } cmd_t;
  // controller sequencing
  typedef enum logic [1:0] {
    HOST_POWER_UP,
    HOST_DLL_LOCK,
    HOST_READY
  } host_state_t;
endpackage

// >>> include/sram_link_if.sv
`timescale 1ns/1ps
// pins between the memory controller and the sram, one beat per half cycle
interface sram_link_if #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 18,
  parameter int LANES  = 2
);
  logic [ADDR_W-1:0] address;
  logic              load_select_n;
  logic              read_write;
  logic [DATA_W-1:0] data_in;
  logic [LANES-1:0]  byte_write_enable_n;
  logic [DATA_W-1:0] data_out;
  logic              data_out_oe_n;
  logic              echo_clock_out;
  logic              dll_disable_n;
  logic              output_clock_tied_high;
  logic              beat_phase;
  modport device (
    input  address, load_select_n, read_write, data_in, byte_write_enable_n,
    input  dll_disable_n, output_clock_tied_high, beat_phase,
    output data_out, data_out_oe_n, echo_clock_out
  );
  modport host (
    output address, load_select_n, read_write, data_in, byte_write_enable_n,
    output dll_disable_n, output_clock_tied_high, beat_phase,
    input  data_out, data_out_oe_n, echo_clock_out
  );
endinterface

// >>> hw/sram_device.sv
`timescale 1ns/1ps
`include "sram_link_defs.svh"
module sram_device #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 18,
  parameter int LANES  = 2
) (
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  sram_link_if.device                   link,
  input  wire logic                     impedance_reference_pin_i,
  output logic [`IMP_CODE_BITS-1:0]     impedance_code_o,
  output logic                          dll_locked_o
);
  localparam int WORD_W = 2 * DATA_W;
  localparam int DEPTH  = 1 << ADDR_W;

  // merge one beat into a stored half word, lane by lane
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [LANES-1:0]  en_n);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int l = 0; l < LANES; l++) begin
      if (!en_n[l]) begin
        r[l*`LANE_BITS +: `LANE_BITS] = new_v[l*`LANE_BITS +: `LANE_BITS];
      end
    end
    return r;
  endfunction

  logic [WORD_W-1:0] mem_q [DEPTH];
  logic [WORD_W-1:0] mem_d [DEPTH];
  sram_link_pkg::cmd_t cmd;
  logic              wr_pend_q, wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [DATA_W-1:0] beat0_q, beat0_d;
  logic [LANES-1:0]  bw0_n_q, bw0_n_d;
  logic              dpend_q, dpend_d;
  logic [ADDR_W-1:0] daddr_q, daddr_d;
  logic              rd_pend_q, rd_pend_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic [WORD_W-1:0] rd_word_q, rd_word_d;
  logic              rd_phase_q, rd_phase_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic              oe_n_q, oe_n_d;
  logic              echo_q, echo_d;
  logic [11:0]       lock_cnt_q, lock_cnt_d;
  logic              locked_q, locked_d;
  logic [10:0]       imp_cnt_q, imp_cnt_d;
  logic [`IMP_CODE_BITS-1:0] code_q, code_d;

  always_comb begin
    if (link.load_select_n) begin
      cmd = sram_link_pkg::CMD_DESELECT;
    end else if (link.read_write) begin
      cmd = sram_link_pkg::CMD_READ;
    end else begin
      cmd = sram_link_pkg::CMD_WRITE;
    end
  end

  // write path: command at n, beat 0 on the true half n+1, beat 1 on the complement half after
  always_comb begin
    mem_d     = mem_q;
    wr_pend_d = wr_pend_q;
    wr_addr_d = wr_addr_q;
    beat0_d   = beat0_q;
    bw0_n_d   = bw0_n_q;
    dpend_d   = dpend_q;
    daddr_d   = daddr_q;
    if (!link.beat_phase) begin
      dpend_d = wr_pend_q;
      if (wr_pend_q) begin
        beat0_d = link.data_in;
        bw0_n_d = link.byte_write_enable_n;
        daddr_d = wr_addr_q;
      end
      // a separate data stage lets back-to-back writes overlap
      wr_pend_d = 1'b0;
      if (cmd == sram_link_pkg::CMD_WRITE && locked_q) begin
        wr_pend_d = 1'b1;
        wr_addr_d = link.address;
      end
    end else if (dpend_q) begin
      // both beats land in one wide word
      mem_d[daddr_q] = {merge_lanes(mem_q[daddr_q][WORD_W-1:DATA_W], link.data_in,
                                    link.byte_write_enable_n),
                        merge_lanes(mem_q[daddr_q][DATA_W-1:0], beat0_q, bw0_n_q)};
      dpend_d = 1'b0;
    end
  end

  // read path and output beats
  always_comb begin
    rd_pend_d  = rd_pend_q;
    rd_addr_d  = rd_addr_q;
    rd_word_d  = rd_word_q;
    rd_phase_d = rd_phase_q;
    dout_d     = dout_q;
    oe_n_d     = oe_n_q;
    echo_d     = link.output_clock_tied_high ? link.beat_phase : ~link.beat_phase;
    if (!link.beat_phase) begin
      oe_n_d     = 1'b1;
      rd_phase_d = 1'b0;
      if (rd_pend_q) begin
        // launch timing follows the input clock pair
        dout_d     = mem_q[rd_addr_q][DATA_W-1:0];
        rd_word_d  = mem_q[rd_addr_q];
        oe_n_d     = 1'b0;
        rd_phase_d = 1'b1;
      end
      rd_pend_d = 1'b0;
      if (cmd == sram_link_pkg::CMD_READ && locked_q) begin
        rd_pend_d = 1'b1;
        rd_addr_d = link.address;
      end
    end else if (rd_phase_q) begin
      dout_d     = rd_word_q[WORD_W-1:DATA_W];
      rd_phase_d = 1'b0;
    end
  end

  // dll lock and impedance calibration
  always_comb begin
    lock_cnt_d = lock_cnt_q;
    locked_d   = locked_q;
    imp_cnt_d  = imp_cnt_q + 11'h001;
    code_d     = code_q;
    // disable pin low restarts the lock wait
    if (!link.dll_disable_n) begin
      lock_cnt_d = 12'h000;
      locked_d   = 1'b0;
    end else if (!locked_q) begin
      lock_cnt_d = lock_cnt_q + 12'h001;
      locked_d   = (lock_cnt_q == 12'(`DLL_LOCK_CYCLES - 1));
    end
    if (imp_cnt_q == 11'(`IMP_PERIOD - 1)) begin
      imp_cnt_d = 11'h000;
      if (impedance_reference_pin_i && code_q != {`IMP_CODE_BITS{1'b1}}) begin
        code_d = code_q + `IMP_CODE_BITS'(1);
      end else if (!impedance_reference_pin_i && code_q != '0) begin
        code_d = code_q - `IMP_CODE_BITS'(1);
      end
    end
  end

  // registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= '0;
      beat0_q    <= '0;
      bw0_n_q    <= '1;
      dpend_q    <= 1'b0;
      daddr_q    <= '0;
      rd_pend_q  <= 1'b0;
      rd_addr_q  <= '0;
      rd_word_q  <= '0;
      rd_phase_q <= 1'b0;
      dout_q     <= '0;
      oe_n_q     <= 1'b1;
      echo_q     <= 1'b0;
      lock_cnt_q <= 12'h000;
      locked_q   <= 1'b0;
      imp_cnt_q  <= 11'h000;
      code_q     <= `IMP_CODE_RESET;
    end else begin
      mem_q      <= mem_d;
      wr_pend_q  <= wr_pend_d;
      wr_addr_q  <= wr_addr_d;
      beat0_q    <= beat0_d;
      bw0_n_q    <= bw0_n_d;
      dpend_q    <= dpend_d;
      daddr_q    <= daddr_d;
      rd_pend_q  <= rd_pend_d;
      rd_addr_q  <= rd_addr_d;
      rd_word_q  <= rd_word_d;
      rd_phase_q <= rd_phase_d;
      dout_q     <= dout_d;
      oe_n_q     <= oe_n_d;
      echo_q     <= echo_d;
      lock_cnt_q <= lock_cnt_d;
      locked_q   <= locked_d;
      imp_cnt_q  <= imp_cnt_d;
      code_q     <= code_d;
    end
  end

  assign link.data_out       = dout_q;
  assign link.data_out_oe_n  = oe_n_q;
  assign link.echo_clock_out = echo_q;
  assign impedance_code_o    = code_q;
  assign dll_locked_o        = locked_q;
endmodule

// >>> hw/sram_host.sv
`timescale 1ns/1ps
`include "sram_link_defs.svh"
// memory controller: one request every two clocks, beat_phase marks half cycles
module sram_host #(
  parameter int ADDR_W          = 8,
  parameter int DATA_W          = 18,
  parameter int LANES           = 2,
  parameter int POWER_UP_CYCLES = `POWER_UP_CYCLES
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  sram_link_if.host                  link,
  input  wire logic                  req_valid_i,
  input  wire logic                  req_write_i,
  input  wire logic [ADDR_W-1:0]     req_addr_i,
  input  wire logic [2*DATA_W-1:0]   req_wdata_i,
  input  wire logic [2*LANES-1:0]    req_wmask_n_i,
  input  wire logic                  dll_enable_i,
  output logic                       req_ready_o,
  output logic                       rd_valid_o,
  output logic [2*DATA_W-1:0]        rd_data_o
);
  sram_link_pkg::host_state_t state_q, state_d;
  logic [15:0]       wait_q, wait_d;
  logic              phase_q, phase_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              load_n_q, load_n_d;
  logic              rw_q, rw_d;
  logic              wr_pend_q, wr_pend_d;
  logic [2*DATA_W-1:0] wdata_q, wdata_d;
  logic [2*LANES-1:0]  mask_q, mask_d;
  logic [DATA_W-1:0] din_q, din_d;
  logic [LANES-1:0]  bw_q, bw_d;
  logic              dll_q, dll_d;
  logic              ready_q, ready_d;
  logic [4:0]        rd_sh_q, rd_sh_d;
  logic              hi_q, hi_d;
  logic [DATA_W-1:0] whi_q, whi_d;
  logic [LANES-1:0]  mhi_q, mhi_d;
  logic [2*DATA_W-1:0] rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;

  // sequencing, command and beat drive
  always_comb begin
    state_d   = state_q;
    wait_d    = wait_q;
    phase_d   = ~phase_q;
    addr_d    = addr_q;
    load_n_d  = 1'b1;
    rw_d      = rw_q;
    wr_pend_d = wr_pend_q;
    wdata_d   = wdata_q;
    mask_d    = mask_q;
    din_d     = din_q;
    bw_d      = '1;
    dll_d     = dll_enable_i;
    ready_d   = 1'b0;
    rd_sh_d   = {rd_sh_q[3:0], 1'b0};
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    hi_d      = 1'b0;
    whi_d     = whi_q;
    mhi_d     = mhi_q;
    // beat one with enables at n+1, beat two at n+1.5
    // second half is kept aside since a new request may replace wdata
    if (wr_pend_q && phase_q) begin
      din_d     = wdata_q[DATA_W-1:0];
      bw_d      = mask_q[LANES-1:0];
      whi_d     = wdata_q[2*DATA_W-1:DATA_W];
      mhi_d     = mask_q[2*LANES-1:LANES];
      hi_d      = 1'b1;
      wr_pend_d = 1'b0;
    end
    if (hi_q) begin
      din_d = whi_q;
      bw_d  = mhi_q;
    end
    unique case (state_q)
      sram_link_pkg::HOST_POWER_UP: begin
        wait_d = wait_q + 16'h0001;
        if (wait_q == 16'(POWER_UP_CYCLES - 1)) begin
          // the power wait covers the lock wait only when it is strictly longer
          state_d = (dll_q && POWER_UP_CYCLES > `DLL_LOCK_CYCLES) ? sram_link_pkg::HOST_READY
                                                                  : sram_link_pkg::HOST_DLL_LOCK;
          wait_d  = 16'h0000;
        end
      end
      sram_link_pkg::HOST_DLL_LOCK: begin
        wait_d = dll_q ? wait_q + 16'h0001 : 16'h0000;
        if (dll_q && wait_q == 16'(`DLL_LOCK_CYCLES)) begin
          state_d = sram_link_pkg::HOST_READY;
        end
      end
      sram_link_pkg::HOST_READY: begin
        // commands reach the pins on a true half
        ready_d = ~phase_q;
        if (!dll_enable_i) begin
          state_d = sram_link_pkg::HOST_DLL_LOCK;
          wait_d  = 16'h0000;
          ready_d = 1'b0;
        end else if (ready_q && req_valid_i) begin
          // command held stable over the edge
          load_n_d = 1'b0;
          rw_d   = ~req_write_i;
          addr_d = req_addr_i;
          wdata_d = req_wdata_i;
          mask_d  = req_wmask_n_i;
          wr_pend_d = req_write_i;
          rd_sh_d[0] = ~req_write_i;
        end
      end
      default: state_d = sram_link_pkg::HOST_POWER_UP;
    endcase
    // collect read beats at n+1.5 and n+2 while output enabled
    if (!link.data_out_oe_n && rd_sh_q[3]) begin
      rdata_d[DATA_W-1:0] = link.data_out;
    end
    if (!link.data_out_oe_n && rd_sh_q[4]) begin
      rdata_d[2*DATA_W-1:DATA_W] = link.data_out;
      rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q   <= sram_link_pkg::HOST_POWER_UP;
      wait_q    <= 16'h0000;
      phase_q   <= 1'b0;
      addr_q    <= '0;
      load_n_q  <= 1'b1;
      rw_q      <= 1'b1;
      wr_pend_q <= 1'b0;
      wdata_q   <= '0;
      mask_q    <= '1;
      din_q     <= '0;
      bw_q      <= '1;
      dll_q     <= 1'b0;
      ready_q   <= 1'b0;
      rd_sh_q   <= 5'h00;
      hi_q      <= 1'b0;
      whi_q     <= '0;
      mhi_q     <= '1;
      rdata_q   <= '0;
      rvalid_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      wait_q    <= wait_d;
      phase_q   <= phase_d;
      addr_q    <= addr_d;
      load_n_q  <= load_n_d;
      rw_q      <= rw_d;
      wr_pend_q <= wr_pend_d;
      wdata_q   <= wdata_d;
      mask_q    <= mask_d;
      din_q     <= din_d;
      bw_q      <= bw_d;
      dll_q     <= dll_d;
      ready_q   <= ready_d;
      rd_sh_q   <= rd_sh_d;
      hi_q      <= hi_d;
      whi_q     <= whi_d;
      mhi_q     <= mhi_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  assign link.address                = addr_q;
  assign link.load_select_n          = load_n_q;
  assign link.read_write             = rw_q;
  assign link.data_in                = din_q;
  assign link.byte_write_enable_n    = bw_q;
  assign link.dll_disable_n          = dll_q;
  assign link.output_clock_tied_high = 1'b1;
  assign link.beat_phase             = phase_q;
  assign req_ready_o                 = ready_q;
  assign rd_valid_o                  = rvalid_q;
  assign rd_data_o                   = rdata_q;
endmodule

// >>> test/sram_link_assertions.sv
`timescale 1ns/1ps
// watches the pins between controller and sram
module sram_link_assertions #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 18,
  parameter int LANES  = 2
) (
  input wire logic              clock_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              load_select_n,
  input wire logic              read_write,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [LANES-1:0]  byte_write_enable_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_out_oe_n,
  input wire logic              echo_clock_out,
  input wire logic              dll_disable_n,
  input wire logic              output_clock_tied_high,
  input wire logic              beat_phase
);
  logic        rd_cmd;
  logic        wr_cmd;
  logic [3:0]  since_rd_q;
  logic [3:0]  since_rd_d;
  logic [11:0] lock_cnt_q;
  logic [11:0] lock_cnt_d;
  // commands seen on a true-clock half
  assign rd_cmd = !load_select_n && read_write && !beat_phase;
  assign wr_cmd = !load_select_n && !read_write && !beat_phase;
  // cycles since last read, cycles since dll enabled
  always_comb begin
    since_rd_d = (since_rd_q == 4'hF) ? since_rd_q : since_rd_q + 4'h1;
    if (rd_cmd) since_rd_d = 4'h0;
    lock_cnt_d = lock_cnt_q[11] ? lock_cnt_q : lock_cnt_q + 12'h001;
    if (!dll_disable_n) lock_cnt_d = 12'h000;
  end
  // helper registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      since_rd_q <= 4'hF;
      lock_cnt_q <= 12'h000;
    end else begin
      since_rd_q <= since_rd_d;
      lock_cnt_q <= lock_cnt_d;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_reset_idle; $fell(rst_i) |-> load_select_n && data_out_oe_n; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
  property p_cmd_true_half; $fell(load_select_n) |-> !beat_phase; endproperty
  a_cmd_true_half: assert property (p_cmd_true_half) else $error("command off true half");
  property p_phase_alt; beat_phase |=> !beat_phase; endproperty
  a_phase_alt: assert property (p_phase_alt) else $error("beat phase stuck");
  property p_read_drives; rd_cmd |-> ##[1:6] !data_out_oe_n; endproperty
  a_read_drives: assert property (p_read_drives) else $error("read not driven");
  property p_oe_two_beats; $fell(data_out_oe_n) |=> !data_out_oe_n; endproperty
  a_oe_two_beats: assert property (p_oe_two_beats) else $error("output beat missing");
  property p_oe_idle; since_rd_q > 4'h6 |-> data_out_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven without read");
  property p_bw_in_beats; byte_write_enable_n != '1 |-> $past(wr_cmd, 2) || $past(wr_cmd, 3); endproperty
  a_bw_in_beats: assert property (p_bw_in_beats) else $error("byte enable outside beats");
  property p_lock_first; !load_select_n |-> lock_cnt_q[11]; endproperty
  a_lock_first: assert property (p_lock_first) else $error("command before lock");
endmodule

// >>> test/ddr_sio_b2_sram_interface_test.sv
`timescale 1ns/1ps
module ddr_sio_b2_sram_interface_test;
  logic        clock_i;
  logic        rst_i;
  logic        req_valid_i;
  logic        req_write_i;
  logic [7:0]  req_addr_i;
  logic [35:0] req_wdata_i;
  logic [3:0]  req_wmask_n_i;
  logic        dll_enable_i;
  logic        req_ready_o;
  logic        rd_valid_o;
  logic [35:0] rd_data_o;
  logic        imp_pin;
  logic [5:0]  imp_code;
  logic [5:0]  imp_prev;
  logic [35:0] exp_q[$];
  logic [3:0]  masks[5] = '{4'h0, 4'hC, 4'h3, 4'hF, 4'h6};
  int          bad_count;
  int          samples_checked;
  int          cycles;
  int          n;
  sram_link_if link ();
  sram_device sram_device_inst (.clock_i(clock_i), .rst_i(rst_i), .link(link),
    .impedance_reference_pin_i(imp_pin), .impedance_code_o(imp_code), .dll_locked_o());
  sram_host #(.POWER_UP_CYCLES(4)) sram_host_inst (.clock_i(clock_i), .rst_i(rst_i), .link(link),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_wmask_n_i(req_wmask_n_i), .dll_enable_i(dll_enable_i),
    .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
  sram_link_assertions sram_link_assertions_inst (.clock_i(clock_i), .rst_i(rst_i),
    .address(link.address), .load_select_n(link.load_select_n), .read_write(link.read_write),
    .data_in(link.data_in), .byte_write_enable_n(link.byte_write_enable_n),
    .data_out(link.data_out), .data_out_oe_n(link.data_out_oe_n),
    .echo_clock_out(link.echo_clock_out), .dll_disable_n(link.dll_disable_n),
    .output_clock_tied_high(link.output_clock_tied_high), .beat_phase(link.beat_phase));
  // compares one result and counts it
  task automatic compare(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one request held until taken
  task automatic req(input logic wr, input logic [7:0] a, input logic [35:0] d, input logic [3:0] m);
    #1;
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = d;
    req_wmask_n_i = m;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 3000);
  endtask
  // read request with its expected word
  task automatic rd(input logic [7:0] a, input logic [35:0] e);
    req(1'b0, a, 36'h0, 4'hF);
    exp_q.push_back(e);
  endtask
  // releases the request lines
  task automatic idle();
    #1;
    req_valid_i = 1'b0;
    @(posedge clock_i);
  endtask
  // merge of old and new word per nine-bit lane
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w, input logic [3:0] m);
    for (int k = 0; k < 4; k++) if (!m[k]) o[k*9 +: 9] = w[k*9 +: 9];
    return o;
  endfunction
  // clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // returned read words and hang limit
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 10000) begin
      compare("timeout", 36'h0, 36'h1);
      stop_test();
    end
    if (rd_valid_o === 1'b1) compare("rd_data", exp_q.size() ? exp_q.pop_front() : 36'hX, rd_data_o);
  end
  // impedance code moves one step at a time
  always @(posedge clock_i) begin
    imp_prev <= imp_code;
    if (!rst_i && imp_code !== imp_prev)
      compare("imp_step", 36'h1, {35'h0, (imp_code - imp_prev) === 6'h01 || (imp_code - imp_prev) === 6'h3F});
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 8'h00;
    req_wdata_i = 36'h0;
    req_wmask_n_i = 4'hF;
    dll_enable_i = 1'b0;
    imp_pin = 1'b1;
    repeat (3) @(posedge clock_i);
    #1 rst_i = 1'b0;
    @(posedge clock_i);
    compare("imp_reset", 36'h20, {30'h0, imp_code});
    repeat (10) @(posedge clock_i);
    #1 dll_enable_i = 1'b1;
    @(posedge clock_i);
    // background then masked write, back to back
    for (int i = 0; i < 5; i++) begin
      req(1'b1, 8'(i), 36'h123456789, 4'h0);
      req(1'b1, 8'(i), 36'hFEDCBA987, masks[i]);
    end
    for (int i = 4; i >= 0; i--) rd(8'(i), merge(36'h123456789, 36'hFEDCBA987, masks[i]));
    idle();
    repeat (30) @(posedge clock_i);
    compare("imp_up", 36'h1, {35'h0, imp_code > 6'h20});
    // dll reset forces a fresh lock wait
    #1 dll_enable_i = 1'b0;
    imp_pin = 1'b0;
    repeat (5) @(posedge clock_i);
    #1 dll_enable_i = 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 3000);
    compare("relock_wait", 36'h1, {35'h0, n >= 2048});
    rd(8'h04, merge(36'h123456789, 36'hFEDCBA987, masks[4]));
    idle();
    n = 0;
    while (exp_q.size() != 0 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    compare("rd_left", 36'h0, 36'(exp_q.size()));
    stop_test();
  end
endmodule
